// [hw/jfcc_top.sv]
`include "jfcc_consts.svh"

module jfcc_top (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic tms,
    input wire logic fuse_blown,
    output logic fuse_sense_current,
    output logic fuse_check_active,
    output logic test_access_deny,
    output logic tap_bypass
);
    // The pin is sampled on every rising clock edge. The detector walks from
    // armed to active on the first fall and to done on the second rise.
    // Every output is registered, so each one answers one edge after
    // the sample that caused it. A host that leaves the pin at its
    // idle-high level never turns the sense path on, even while the
    // mode is active.

    // Detector state and its next value
    jfcc_pkg::jfcc_state_t state_reg;
    jfcc_pkg::jfcc_state_t state_next;

    // Rising-edge counter; two bits are enough to hold the end count
    logic [`JFCC_RISE_CNT_W-1:0] rise_cnt_reg;
    logic [`JFCC_RISE_CNT_W-1:0] rise_cnt_next;

    // Pin history for the edge detector
    logic tms_prev_reg;
    logic tms_prev_next;

    // Marks the first sampling edge after power-on reset
    logic first_reg;
    logic first_next;

    // Next values of the registered outputs
    logic sense_next;
    logic active_next;
    logic deny_next;
    logic bypass_next;

    // Decoded pin and counter conditions
    logic tms_low;
    logic tms_rise;
    logic tms_fall;
    logic tms_fall_late;
    logic cnt_full;
    logic cnt_end_next;
    logic go_active;
    logic go_done;
    logic fuse_intact;

    // True when a count has reached the value that ends the mode
    function automatic logic jfcc_at_end(
        input logic [`JFCC_RISE_CNT_W-1:0] cnt
    );
        return (cnt == `JFCC_RISE_END);
    endfunction

    // Level decode of the sampled pin
    assign tms_low = !tms;

    // Edge detection on the synchronous pin. The history resets to the
    // idle-high level, so a high pin after reset never reads as a fall
    // and the first sample can never read as a rise.
    assign tms_rise = !first_reg && tms && !tms_prev_reg;
    assign tms_fall_late = tms_low && tms_prev_reg;

    // The first edge after reset has no real history; a low level there
    // stands for the activating fall, which covers a pin held low while
    // power came up
    assign tms_fall = first_reg ? tms_low : tms_fall_late;

    // Counter decode, shared by both live states
    assign cnt_full = jfcc_at_end(rise_cnt_reg);
    assign cnt_end_next = jfcc_at_end(rise_cnt_next);

    // Saturating rise counter; it never wraps, so a long burst of pin
    // activity cannot bring the count round and re-arm the mode
    assign rise_cnt_next = (tms_rise && !cnt_full) ?
        rise_cnt_reg + `JFCC_RISE_STEP : rise_cnt_reg;

    // Transition requests; the end count wins over a fall in one cycle
    assign go_done = cnt_end_next;
    assign go_active = tms_fall && !go_done;

    // Mode sequencing: armed until the first fall, active until the
    // second rise, then done until the next power-on reset
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            jfcc_pkg::JFCC_ARMED: begin
                if (go_done) begin
                    state_next = jfcc_pkg::JFCC_DONE;
                end else if (go_active) begin
                    state_next = jfcc_pkg::JFCC_ACTIVE;
                end
            end
            jfcc_pkg::JFCC_ACTIVE: begin
                if (go_done) begin
                    state_next = jfcc_pkg::JFCC_DONE;
                end
            end
            jfcc_pkg::JFCC_DONE: begin
                // No pin activity leaves this state; only reset does
                state_next = jfcc_pkg::JFCC_DONE;
            end
            default: begin
                // An unused code falls to the safe, inactive state
                state_next = jfcc_pkg::JFCC_DONE;
            end
        endcase
    end

    // History and first-edge marker next values
    assign tms_prev_next = tms;
    assign first_next = 1'h0;

    // The mode output follows the state the detector moves to, so it
    // stands in the same cycle as the state register
    assign active_next = (state_next == jfcc_pkg::JFCC_ACTIVE);

    // Sense path only while active with the pin low. A blown fuse keeps
    // it off: there is nothing left to test and the current is wasted.
    assign fuse_intact = !fuse_blown;
    assign sense_next = active_next && tms_low && fuse_intact;

    // Lock-out follows the fuse state; there is no way back short of a
    // new fuse, so no override is offered
    assign deny_next = fuse_blown;
    assign bypass_next = fuse_blown;

    // Detector state; every power-on reset re-arms the mode, which is
    // the only way out of the done state
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= jfcc_pkg::JFCC_ARMED;
        end else begin
            state_reg <= state_next;
        end
    end

    // Rise counter; cleared by reset so the count always starts from
    // power-up and never carries over from an earlier session
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rise_cnt_reg <= `JFCC_RISE_RST;
        end else begin
            rise_cnt_reg <= rise_cnt_next;
        end
    end

    // Pin history; resets to the idle-high level so that release of
    // reset with the pin high does not make a false edge
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tms_prev_reg <= `JFCC_TMS_RST;
        end else begin
            tms_prev_reg <= tms_prev_next;
        end
    end

    // First-edge marker; high for exactly one sampling edge after
    // reset is released
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            first_reg <= `JFCC_FIRST_RST;
        end else begin
            first_reg <= first_next;
        end
    end

    // Sense path enable; off during reset so no current flows while
    // the supply is still coming up
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            fuse_sense_current <= `JFCC_OUT_RST;
        end else begin
            fuse_sense_current <= sense_next;
        end
    end

    // Mode flag, registered so the outside sees a clean level that
    // never glitches with the pin
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            fuse_check_active <= `JFCC_OUT_RST;
        end else begin
            fuse_check_active <= active_next;
        end
    end

    // Access denial; follows the fuse input one edge late
    // like every other output
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            test_access_deny <= `JFCC_OUT_RST;
        end else begin
            test_access_deny <= deny_next;
        end
    end

    // Bypass request to the test access block; kept apart from the
    // denial so each can be routed to its own consumer
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tap_bypass <= `JFCC_OUT_RST;
        end else begin
            tap_bypass <= bypass_next;
        end
    end
endmodule

// [hw/jfcc_consts.svh]
`ifndef JFCC_CONSTS_SVH
`define JFCC_CONSTS_SVH
// Rising-edge count width and the count that ends the mode
`define JFCC_RISE_CNT_W 2
`define JFCC_RISE_END 2'h2
`define JFCC_RISE_RST 2'h0
`define JFCC_RISE_STEP 2'h1
// Reset values of the pin history, first-edge marker and outputs
`define JFCC_TMS_RST 1'h1
`define JFCC_FIRST_RST 1'h1
`define JFCC_OUT_RST 1'h0
`endif

// [hw/jfcc_pkg.sv]
package jfcc_pkg;
    typedef enum logic [1:0] {
        JFCC_ARMED,
        JFCC_ACTIVE,
        JFCC_DONE
    } jfcc_state_t;
endpackage

// [bench/jfcc_chk.sv]
module jfcc_chk (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic tms,
    input wire logic fuse_blown,
    input wire logic fuse_sense_current,
    input wire logic fuse_check_active,
    input wire logic test_access_deny,
    input wire logic tap_bypass
);
timeunit 1ns;
timeprecision 1ns;
// One clock domain; reset aborts every property
default clocking @(posedge mclk);
endclocking
default disable iff (!arst_n);
property p_sense;
    fuse_sense_current |-> fuse_check_active && !$past(tms);
endproperty
a_sense: assert property (p_sense) else $error("sense off mode");
property p_sense_on;
    fuse_check_active && !tms && !fuse_blown |=> fuse_sense_current;
endproperty
a_sense_on: assert property (p_sense_on) else $error("sense missing");
property p_go;
    $rose(fuse_check_active) |-> !$past(tms);
endproperty
a_go: assert property (p_go) else $error("mode rose on high");
property p_end;
    $fell(fuse_check_active) |-> $past(tms);
endproperty
a_end: assert property (p_end) else $error("mode fell on low");
property p_stay_off;
    $fell(fuse_check_active) |=> !fuse_check_active [*8];
endproperty
a_stay_off: assert property (p_stay_off) else $error("mode re-armed");
property p_deny;
    fuse_blown |=> test_access_deny;
endproperty
a_deny: assert property (p_deny) else $error("no deny");
property p_bypass;
    fuse_blown |=> tap_bypass;
endproperty
a_bypass: assert property (p_bypass) else $error("no bypass");
property p_no_lock;
    !fuse_blown |=> !test_access_deny && !tap_bypass;
endproperty
a_no_lock: assert property (p_no_lock) else $error("false lock");
endmodule
bind jfcc_top jfcc_chk u_chk (
    .mclk(mclk),
    .arst_n(arst_n),
    .tms(tms),
    .fuse_blown(fuse_blown),
    .fuse_sense_current(fuse_sense_current),
    .fuse_check_active(fuse_check_active),
    .test_access_deny(test_access_deny),
    .tap_bypass(tap_bypass)
);

// [bench/jfcc_tool.sv]
module jfcc_tool (
    input wire logic lvl,
    output logic tms
);
timeunit 1ns;
timeprecision 1ns;
// The tool drives the pin level it is given; it idles high
assign tms = lvl;
endmodule

// [bench/tb.sv]
module tb;
timeunit 1ns;
timeprecision 1ns;
logic mclk = 1'h0, arst_n = 1'h0, fb = 1'h0, lvl = 1'h1;
logic tms, sc, ac, dn, bp;
logic m_first, m_prev, m_act;
logic [1:0] m_rise;
int n_mismatch = 0, n_checks = 0, seed = 42;
// Clock
always #20 mclk = ~mclk; // 25 MHz
jfcc_tool u_tool (.lvl(lvl), .tms(tms));
jfcc_top dut (.mclk(mclk), .arst_n(arst_n), .tms(tms), .fuse_blown(fb),
    .fuse_sense_current(sc), .fuse_check_active(ac),
    .test_access_deny(dn), .tap_bypass(bp));
// Expected sense enable from mode, pin and fuse
function automatic logic exp_sense(logic act, t, f);
    return act && !t && !f;
endfunction
task chk(string n, logic g, e);
    n_checks++;
    n_mismatch += (g !== e);
    if (g !== e) $display("FAIL %s exp %b got %b", n, e, g);
endtask
// Rule model: rises after the first sample count; two end the mode
task model(logic t);
    if (!m_first && t && !m_prev && m_rise < 2'h2) m_rise++;
    if (m_rise == 2'h2) m_act = 1'h0;
    else if (!t && (m_first || m_prev)) m_act = 1'h1;
    m_first = 1'h0;
    m_prev = t;
endtask
// Look at all outputs one edge after the sample
task look(logic v, f);
    @(posedge mclk) #1;
    model(v);
    chk("act", ac, m_act);
    chk("sns", sc, exp_sense(m_act, v, f));
    chk("dny", dn, f);
    chk("byp", bp, f);
endtask
task s(logic v, f = 1'h0);
    @(negedge mclk) {lvl, fb} <= {v, f};
    look(v, f);
endtask
// Power-on reset with the pin held at v, then the first edge
task por(logic v);
    @(negedge mclk);
    arst_n = 1'h0;
    lvl = v;
    fb = 1'h0;
    {m_first, m_prev, m_act, m_rise} = {1'h1, 1'h1, 1'h0, 2'h0};
    repeat (6) @(negedge mclk);
    arst_n = 1'h1;
    look(v, 1'h0);
endtask
task report_and_stop;
    $display("%0d checks %0d fails", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
endtask
initial begin
    // Low at power-up, sense on, gated by the fuse, then done
    por(1'h0);
    s(1'h0);
    chk("sns", sc, 1'h1);
    s(1'h1);
    s(1'h0, 1'h1);
    s(1'h1);
    chk("act", ac, 1'h0);
    repeat (30) s(1'($random(seed)), 1'($random(seed)));
    chk("act", ac, 1'h0);
    $display("test low_power_up done");
    // High at power-up: first fall activates, second rise ends
    por(1'h1);
    s(1'h1);
    s(1'h0);
    chk("act", ac, 1'h1);
    s(1'h1);
    s(1'h0);
    s(1'h1);
    chk("act", ac, 1'h0);
    $display("test high_power_up done");
    // Random resets and pin activity
    repeat (20) begin
        por(1'($random(seed)));
        repeat (12) s(1'($random(seed)), 1'($random(seed)));
    end
    $display("test random done");
    report_and_stop;
end
endmodule
